//--- logic/ior_defines.svh
// constants of the inertial output register block
//
// Contract
// - a read of fault_flags returns its contents, then clears all its bits; the code keeps any bit whose event comes in the read cycle
// - each fault flag is sticky until a read of fault_flags clears it
// - an overrun still present after a clearing read sets its flag again
// - rate high and low words form one 32-bit twos value, high on top
// - accel high and low words form one 32-bit twos value, high on top
// - rate high word is twos complement, zero is 0x0000, 0.1 dps per count
// - accel high word twos complement, 40 g range, 1.25 mg per count
// - each low word holds 16 fraction bits below the high word lsb
// - rate low words at 0x04, 0x08, 0x0C, high word two bytes above
// - accel low words at 0x10, 0x14, 0x18, high word two bytes above
// - temperature is a 16-bit twos read-only word at 0x1C
// - temperature is 0.1 degC per count, zero degrees reads 0x0000
// - flag bit 3 set when a transfer clock count is not a multiple of 16
// - flag bit 1 set on any internal data path overrun
// - flag bit 5 set when a self test ends with a sensor failing
`ifndef IOR_DEFINES_SVH
`define IOR_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define IOR_ADDR_FAULT_FLAGS 7'h02
`define IOR_ADDR_RATE_X_FRAC 7'h04
`define IOR_ADDR_RATE_X_WORD 7'h06
`define IOR_ADDR_RATE_Y_FRAC 7'h08
`define IOR_ADDR_RATE_Y_WORD 7'h0A
`define IOR_ADDR_RATE_Z_FRAC 7'h0C
`define IOR_ADDR_RATE_Z_WORD 7'h0E
`define IOR_ADDR_ACCEL_X_FRAC 7'h10
`define IOR_ADDR_ACCEL_X_WORD 7'h12
`define IOR_ADDR_ACCEL_Y_FRAC 7'h14
`define IOR_ADDR_ACCEL_Y_WORD 7'h16
`define IOR_ADDR_ACCEL_Z_FRAC 7'h18
`define IOR_ADDR_ACCEL_Z_WORD 7'h1A
`define IOR_ADDR_TEMPERATURE 7'h1C

// ----------------------------------------------------------------------------
// fault flag bit positions and reset values
// ----------------------------------------------------------------------------
`define IOR_FLAG_OVERRUN 1
`define IOR_FLAG_FRAMING 3
`define IOR_FLAG_SELFTEST 5
`define IOR_FLAGS_RESET 16'h0000
`define IOR_WORD_RESET 16'h0000
`define IOR_FRAME_MASK 4'hF

`endif

//--- logic/ior_pkg.sv
// types of the inertial output register block
`default_nettype none
package ior_pkg;
    // one inertial sample: three rate and three accel axes, 32 bits each
    typedef struct packed {
        logic [2:0][31:0] rate;
        logic [2:0][31:0] accel;
        logic [15:0] temp;
    } ior_sample_s;

    // register access request from the serial port engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
        logic [15:0] wdata;
    } ior_req_s;

    // error condition inputs
    typedef struct packed {
        logic overrun;
        logic selftest_fail;
        logic frame_end;
        logic [3:0] frame_clk_cnt;
    } ior_cond_s;

    // all block state
    typedef struct packed {
        ior_sample_s data;
        logic [15:0] flags;
        logic [15:0] rdata;
        logic rvalid;
        logic [2:0] sync_ovr;
        logic [2:0] sync_st;
    } ior_state_s;
endpackage
`default_nettype wire

//--- logic/ior_regs.sv
// output register set of a six-axis inertial sensor
`timescale 1ns/1ps
`default_nettype none
`include "ior_defines.svh"

module ior_regs
(
    input wire logic CLK_I, // 10 MHz clock
    input wire logic RST_I, // async reset, active high
    input wire ior_pkg::ior_sample_s SAMPLE_I, // new sample from data path
    input wire logic SAMPLE_VLD_I, // one-cycle pulse, sample is complete
    input wire ior_pkg::ior_req_s REQ_I, // register request, same domain
    input wire ior_pkg::ior_cond_s COND_I, // error conditions
    output logic [15:0] RDATA_O, // read data
    output logic RVALID_O // one-cycle pulse, read data valid
);
    import ior_pkg::*;

    ior_state_s st_r;
    ior_state_s st_nxt;
    logic [15:0] set_bits;
    logic [15:0] word_mux;

    // ------------------------------------------------------------------------
    // error sources
    // ------------------------------------------------------------------------
    // overrun and self test come from other logic domains: two-stage sync,
    // the third stage is an edge detector fed from the second stage only
    always_comb
    begin
        set_bits = 16'h0000;
        set_bits[`IOR_FLAG_OVERRUN] = st_r.sync_ovr[1] & ~st_r.sync_ovr[2];
        set_bits[`IOR_FLAG_SELFTEST] = st_r.sync_st[1] & ~st_r.sync_st[2];
        // frame end with clock count not a multiple of 16
        set_bits[`IOR_FLAG_FRAMING] = COND_I.frame_end &
            ((COND_I.frame_clk_cnt & `IOR_FRAME_MASK) != 4'h0);
        // a level-held overrun keeps setting its flag while present; self test sets on its rising edge only
        if (st_r.sync_ovr[1])
        begin
            set_bits[`IOR_FLAG_OVERRUN] = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------------
    // each pair reads as one 32-bit twos value split in high and low words
    always_comb
    begin
        case (REQ_I.addr)
            `IOR_ADDR_FAULT_FLAGS: word_mux = st_r.flags;
            `IOR_ADDR_RATE_X_FRAC: word_mux = st_r.data.rate[0][15:0];
            `IOR_ADDR_RATE_X_WORD: word_mux = st_r.data.rate[0][31:16];
            `IOR_ADDR_RATE_Y_FRAC: word_mux = st_r.data.rate[1][15:0];
            `IOR_ADDR_RATE_Y_WORD: word_mux = st_r.data.rate[1][31:16];
            `IOR_ADDR_RATE_Z_FRAC: word_mux = st_r.data.rate[2][15:0];
            `IOR_ADDR_RATE_Z_WORD: word_mux = st_r.data.rate[2][31:16];
            `IOR_ADDR_ACCEL_X_FRAC: word_mux = st_r.data.accel[0][15:0];
            `IOR_ADDR_ACCEL_X_WORD: word_mux = st_r.data.accel[0][31:16];
            `IOR_ADDR_ACCEL_Y_FRAC: word_mux = st_r.data.accel[1][15:0];
            `IOR_ADDR_ACCEL_Y_WORD: word_mux = st_r.data.accel[1][31:16];
            `IOR_ADDR_ACCEL_Z_FRAC: word_mux = st_r.data.accel[2][15:0];
            `IOR_ADDR_ACCEL_Z_WORD: word_mux = st_r.data.accel[2][31:16];
            `IOR_ADDR_TEMPERATURE: word_mux = st_r.data.temp;
            default: word_mux = 16'h0000; // unmapped reads as zero
        endcase
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync_ovr = {st_r.sync_ovr[1:0], COND_I.overrun};
        st_nxt.sync_st = {st_r.sync_st[1:0], COND_I.selftest_fail};
        // whole sample loads in one edge, so halves never mix
        if (SAMPLE_VLD_I)
        begin
            st_nxt.data = SAMPLE_I;
        end
        // writes are ignored: REQ_I.wr and wdata never reach state
        st_nxt.rvalid = REQ_I.rd;
        st_nxt.rdata = REQ_I.rd ? word_mux : st_r.rdata;
        // clearing read, but a new event in the same cycle wins
        if (REQ_I.rd && REQ_I.addr == `IOR_ADDR_FAULT_FLAGS)
        begin
            st_nxt.flags = set_bits;
        end
        else
        begin
            st_nxt.flags = st_r.flags | set_bits;
        end
    end

    // state register
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st_r <= '0;
            st_r.flags <= `IOR_FLAGS_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign RDATA_O = st_r.rdata;
    assign RVALID_O = st_r.rvalid;
endmodule // ior_regs
`default_nettype wire

//--- sim/ior_host.sv
// host model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module ior_host
(
    input wire logic clk_i, // clock
    input wire logic [15:0] rdata_i, // read data
    output var ior_pkg::ior_req_s req_o // request
);
    import ior_pkg::*;
    initial req_o = '0;
    // one access: raised after a falling edge, dropped after the answer edge
    // each access stands for one whole 16-clock serial frame
    task automatic xfer(input logic w, input logic [6:0] a, output logic [15:0] d);
        @(negedge clk_i);
        req_o = '{rd: !w, wr: w, addr: a, wdata: 16'hFFFF};
        @(negedge clk_i);
        req_o = '0;
        d = rdata_i;
    endtask
endmodule // ior_host
`default_nettype wire

//--- sim/ior_regs_props.sv
// checker of the output register block
`timescale 1ns/1ps
`default_nettype none
module ior_regs_props
(
    input wire logic CLK_I, // clock
    input wire logic RST_I, // reset
    input wire ior_pkg::ior_sample_s SAMPLE_I, // sample
    input wire logic SAMPLE_VLD_I, // load
    input wire ior_pkg::ior_req_s REQ_I, // request
    input wire ior_pkg::ior_cond_s COND_I, // faults
    input wire logic [15:0] RDATA_O, // data
    input wire logic RVALID_O // valid
);
    import ior_pkg::*;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    ior_sample_s s_r;
    wire fr = REQ_I.rd && REQ_I.addr == 7'h02; // flag read
    // shadow of the last loaded sample
    always_ff @(posedge CLK_I or posedge RST_I)
        s_r <= RST_I ? '0 : (SAMPLE_VLD_I ? SAMPLE_I : s_r);
    read_answer_a: assert property (REQ_I.rd |=> RVALID_O)
        else $error("no answer");
    stray_valid_a: assert property (!REQ_I.rd |=> !RVALID_O)
        else $error("stray valid");
    data_hold_a: assert property (!REQ_I.rd |=> $stable(RDATA_O))
        else $error("data moved");
    frame_set_a: assert property (COND_I.frame_end && COND_I.frame_clk_cnt != 4'h0
        ##1 !REQ_I.rd ##1 fr |=> RDATA_O[3]) else $error("frame flag lost");
    flag_clr_a: assert property (!COND_I.frame_end throughout (fr ##2 fr)
        |=> !RDATA_O[3]) else $error("flag not cleared");
    reserved_zero_a: assert property (fr |=> (RDATA_O & 16'hFFD5) == 16'h0000)
        else $error("reserved set");
    lo_word_a: assert property ((REQ_I.rd && REQ_I.addr == 7'h04)
        |=> RDATA_O == $past(s_r.rate[0][15:0])) else $error("bad low word");
    hi_word_a: assert property ((REQ_I.rd && REQ_I.addr == 7'h1A)
        |=> RDATA_O == $past(s_r.accel[2][31:16])) else $error("bad high word");
    cover property (fr);
    cover property (REQ_I.wr);
    cover property (SAMPLE_VLD_I ##2 REQ_I.wr);
endmodule // ior_regs_props
bind ior_regs ior_regs_props u_props (.CLK_I, .RST_I, .SAMPLE_I, .SAMPLE_VLD_I, .REQ_I,
    .COND_I, .RDATA_O, .RVALID_O);
`default_nettype wire

//--- sim/ior_regs_tb.sv
// self-checking bench of the output register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %0t got %h", $time, g); end end
module ior_regs_tb;
    import ior_pkg::*;
    logic clk = 0, rst = 1, vld = 0, rv;
    logic [15:0] rdata, d;
    logic [31:0] v [6];
    ior_sample_s smp = '0;
    ior_cond_s cond = '0;
    ior_req_s req;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    always #50 clk = ~clk;
    ior_regs dut (.CLK_I(clk), .RST_I(rst), .SAMPLE_I(smp), .SAMPLE_VLD_I(vld), .REQ_I(req),
        .COND_I(cond), .RDATA_O(rdata), .RVALID_O(rv));
    ior_host host (.clk_i(clk), .rdata_i(rdata), .req_o(req));
    // read one register, expect a valid answer
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        host.xfer(1'b0, a, d);
        `CHK({rv, d}, {1'b1, e})
    endtask
    // load a sample, change the input, write over it, read all words
    task automatic t_data;
        for (int k = 0; k < 6; k++)
            v[k] = 32'hB1E0_8001 + k * 32'h0101_0101;
        smp = '{rate: {v[2], v[1], v[0]}, accel: {v[5], v[4], v[3]}, temp: 16'hFF06};
        @(negedge clk);
        vld = 1;
        @(negedge clk);
        vld = 0;
        smp = '1;
        host.xfer(1'b1, 7'h06, d);
        for (int k = 0; k < 6; k++)
        begin
            rd(7'(4 + 4 * k), v[k][15:0]);
            rd(7'(6 + 4 * k), v[k][31:16]);
        end
        rd(7'h1C, 16'hFF06);
    endtask
    // raise each fault condition and read the flags
    task automatic t_flags;
        @(negedge clk);
        cond.frame_end = 1;
        cond.frame_clk_cnt = 4'h5;
        @(negedge clk);
        cond.frame_end = 0;
        rd(7'h02, 16'h0008);
        rd(7'h02, 16'h0000);
        // a frame of whole 16-clock units must not raise the framing flag
        @(negedge clk);
        cond.frame_end = 1;
        cond.frame_clk_cnt = 4'h0;
        @(negedge clk);
        cond.frame_end = 0;
        rd(7'h02, 16'h0000);
        cond.overrun = 1;
        repeat (5) @(negedge clk);
        rd(7'h02, 16'h0002);
        rd(7'h02, 16'h0002);
        cond.overrun = 0;
        cond.selftest_fail = 1;
        repeat (5) @(negedge clk);
        cond.selftest_fail = 0;
        repeat (5) @(negedge clk);
        rd(7'h02, 16'h0022);
        rd(7'h02, 16'h0000);
    endtask
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 0;
        t_data();
        t_flags();
        wrap_up();
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
            n_mismatch++;
        if (cyc == 1000)
            wrap_up();
    end
endmodule // ior_regs_tb
`default_nettype wire
